// >>> logic/cpuc_cfg.svh
`ifndef CPUC_CFG_SVH
`define CPUC_CFG_SVH
`define CPUC_FLG_I         7
`define CPUC_FLG_T         6
`define CPUC_FLG_H         5
`define CPUC_FLG_S         4
`define CPUC_FLG_V         3
`define CPUC_FLG_N         2
`define CPUC_FLG_Z         1
`define CPUC_FLG_C         0
`define CPUC_FLAGS_RST     8'h00
`define CPUC_SP_RST        16'h0000
`define CPUC_IO_BASE       7'h20
`define CPUC_IO_LAST       7'h5F
`define CPUC_ADR_FLAGS     8'h3F
`define CPUC_ADR_SP_LO     8'h3D
`define CPUC_ADR_SP_HI     8'h3E
`define CPUC_ADR_CODE_HI   8'h40
`define CPUC_ADR_CODE_LO   8'h41
`define CPUC_ADR_FLASH     8'h42
`define CPUC_ADR_STATUS    8'h43
`define CPUC_BOOT_START    16'h7000
`define CPUC_IRQ_NUM       8
`define CPUC_VEC_STEP      16'h0002
`endif

// >>> logic/cpuc_pkg.sv
package cpuc_pkg;
    typedef enum logic [3:0] {
        CPUC_ADD, CPUC_ADC, CPUC_SUB, CPUC_SBC, CPUC_AND, CPUC_OR, CPUC_EOR,
        CPUC_COM, CPUC_NEG, CPUC_INC, CPUC_DEC, CPUC_LSR, CPUC_MOV, CPUC_NOP
    } cpuc_alu_t;
    typedef enum logic [3:0] {
        CPUC_OP_ALU, CPUC_OP_BST, CPUC_OP_BLD, CPUC_OP_SEI, CPUC_OP_CLI,
        CPUC_OP_CALL, CPUC_OP_RET, CPUC_OP_RETURN_FROM_IRQ_OP, CPUC_OP_SPM, CPUC_OP_LDP,
        CPUC_OP_NONE
    } cpuc_op_t;
    typedef enum logic [1:0] {
        CPUC_ST_RUN, CPUC_ST_PUSH, CPUC_ST_POP
    } cpuc_st_t;
endpackage : cpuc_pkg

// >>> logic/cpuc_core.sv
// Functional notes
// - Thirty-two 8-bit working registers, each read or written in one cycle.
// - Typical ALU op reads two registers, computes, writes back in one cycle.
// - Next word is fetched while the current instruction executes.
// - Registers 30 and 31 pair into one 16-bit pointer; it also indexes flash.
// - Instructions are one 16-bit word or two words (32 bits).
// - Flash store into application section only from code in boot section.
// - Call and interrupt entry push the return address into data SRAM.
// - Stack pointer readable and writable in I/O space; software sets it.
// - Each interrupt has its own vector; lowest vector served first.
// - I/O space of 64 addresses, also data addresses 0x20 to 0x5F.
// - ALU does register-register, register-immediate, single-register ops in one cycle.
// - Flags updated after every ALU operation from its result.
// - Flags are neither saved nor restored by hardware on interrupts.
// - Bit 7 is global interrupt enable; zero blocks all interrupts.
// - Interrupt entry clears bit 7; return-from-interrupt sets it; set/clear ops too.
// - Bit 6 is copy store for bit-store and bit-load ops.
// - Bit 5 holds half carry out of the low nibble.
// - Bit 4 equals negative xor overflow, except after a register-port write to the flags.
// - Bit 3 holds two's complement overflow.
// - Bit 2 is set on a negative result.
// - Bit 1 is set on a zero result.
// - Bit 0 holds the carry.
// - Call and interrupt entry subtract two from the stack pointer; returns add two.
`timescale 1ns/1ps
`include "cpuc_cfg.svh"
module cpuc_core (
    input  wire logic                   I_REF_CLK,
    input  wire logic                   I_RST,
    input  wire logic                   I_INSTR_VALID,
    input  wire cpuc_pkg::cpuc_op_t     I_OP,
    input  wire cpuc_pkg::cpuc_alu_t    I_ALU_FN,
    input  wire logic                   I_USE_IMM,
    input  wire logic                   I_TWO_WORD,
    input  wire logic [4:0]             I_RD,
    input  wire logic [4:0]             I_RR,
    input  wire logic [7:0]             I_IMM,
    input  wire logic [2:0]             I_BIT,
    input  wire logic [15:0]            I_TARGET,
    input  wire logic [15:0]            I_FETCH_WORD,
    input  wire logic [`CPUC_IRQ_NUM-1:0] I_IRQ,
    input  wire logic [7:0]             I_MEM_RDATA,
    input  wire logic [7:0]             I_ADDR,
    input  wire logic [7:0]             I_WDATA,
    input  wire logic                   I_WR,
    input  wire logic                   I_RD_STB,
    output logic [7:0]                  O_RDATA,
    output logic [15:0]                 O_PC,
    output logic [7:0]                  O_FLAGS,
    output logic [15:0]                 O_MEM_ADDR,
    output logic [7:0]                  O_MEM_WDATA,
    output logic                        O_MEM_WE,
    output logic [15:0]                 O_FLASH_ADDR,
    output logic                        O_FLASH_WE,
    output logic                        O_IRQ_ACK,
    output logic [2:0]                  O_IRQ_NUM,
    output logic                        O_SPM_REFUSED
);
    typedef struct packed {
        logic [31:0][7:0]     rf;
        logic [7:0]           flags;
        logic [15:0]          sp;
        logic [15:0]          pc;
        logic [15:0]          ir;
        logic [15:0]          ir2;
        cpuc_pkg::cpuc_st_t   st;
        logic [1:0]           step;
        logic                 return_from_irq_op;
        logic [15:0]          ret_pc;
        logic [15:0]          dest;
        logic [7:0]           rdata;
        logic [15:0]          mem_addr;
        logic [7:0]           mem_wdata;
        logic                 mem_we;
        logic [15:0]          fl_addr;
        logic                 fl_we;
        logic                 ack;
        logic [2:0]           irq_num;
        logic                 spm_ref;
    } cpuc_state_t;

    cpuc_state_t r;
    cpuc_state_t next_r;
    logic [`CPUC_IRQ_NUM-1:0] irq_m;
    logic [`CPUC_IRQ_NUM-1:0] irq_s;

    always_ff @(posedge I_REF_CLK) begin
        irq_m <= I_IRQ;
        irq_s <= irq_m;
    end

    logic [7:0] a;
    logic [7:0] b;
    logic [7:0] res;
    logic       cin;
    logic       c;
    logic       h;
    logic       v;
    logic       wr_res;
    logic [8:0] sum;
    logic [4:0] lo;
    logic [2:0] pick;
    logic       found;
    logic [15:0] zptr;

    // Single-cycle ALU with flag terms
    always_comb begin
        a = r.rf[I_RD];
        b = I_USE_IMM ? I_IMM : r.rf[I_RR];
        cin = 1'b0;
        sum = 9'h000;
        lo = 5'h00;
        res = a;
        c = r.flags[`CPUC_FLG_C];
        h = r.flags[`CPUC_FLG_H];
        v = 1'b0;
        wr_res = 1'b1;
        case (I_ALU_FN)
            cpuc_pkg::CPUC_ADD, cpuc_pkg::CPUC_ADC: begin
                cin = (I_ALU_FN == cpuc_pkg::CPUC_ADC) & r.flags[`CPUC_FLG_C];
                sum = {1'b0, a} + {1'b0, b} + {8'h00, cin};
                lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
                res = sum[7:0];
                c = sum[8];
                h = lo[4];
                v = (a[7] == b[7]) & (res[7] != a[7]);
            end
            cpuc_pkg::CPUC_SUB, cpuc_pkg::CPUC_SBC: begin
                cin = (I_ALU_FN == cpuc_pkg::CPUC_SBC) & r.flags[`CPUC_FLG_C];
                sum = {1'b0, a} - {1'b0, b} - {8'h00, cin};
                lo = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, cin};
                res = sum[7:0];
                c = sum[8];
                h = lo[4];
                v = (a[7] != b[7]) & (res[7] != a[7]);
            end
            cpuc_pkg::CPUC_AND: res = a & b;
            cpuc_pkg::CPUC_OR:  res = a | b;
            cpuc_pkg::CPUC_EOR: res = a ^ b;
            cpuc_pkg::CPUC_COM: begin
                res = ~a;
                c = 1'b1;
            end
            cpuc_pkg::CPUC_NEG: begin
                res = 8'h00 - a;
                c = (res != 8'h00);
                h = res[3] | a[3];
                v = (res == 8'h80);
            end
            cpuc_pkg::CPUC_INC: begin
                res = a + 8'h01;
                v = (res == 8'h80);
            end
            cpuc_pkg::CPUC_DEC: begin
                res = a - 8'h01;
                v = (res == 8'h7F);
            end
            cpuc_pkg::CPUC_LSR: begin
                res = {1'b0, a[7:1]};
                c = a[0];
                v = a[0];
            end
            cpuc_pkg::CPUC_MOV: res = b;
            default: wr_res = 1'b0;
        endcase
    end

    // Lowest vector wins
    always_comb begin
        pick = 3'h0;
        found = 1'b0;
        for (int k = `CPUC_IRQ_NUM - 1; k >= 0; k--) begin
            if (irq_s[k]) begin
                pick = 3'(k);
                found = 1'b1;
            end
        end
    end

    assign zptr = {r.rf[31], r.rf[30]};

    always_comb begin
        next_r = r;
        next_r.mem_we = 1'b0;
        next_r.fl_we = 1'b0;
        next_r.ack = 1'b0;
        next_r.spm_ref = 1'b0;
        next_r.ir = I_FETCH_WORD;
        if (r.st == cpuc_pkg::CPUC_ST_PUSH) begin
            next_r.mem_addr = r.sp;
            next_r.mem_wdata = r.step[0] ? r.ret_pc[15:8] : r.ret_pc[7:0];
            next_r.mem_we = 1'b1;
            next_r.sp = r.sp - 16'h0001;
            next_r.step = {1'b0, ~r.step[0]};
            if (r.step[0]) begin
                next_r.st = cpuc_pkg::CPUC_ST_RUN;
                next_r.pc = r.dest;
            end
        end else if (r.st == cpuc_pkg::CPUC_ST_POP) begin
            // Read data trails the address by one cycle: high byte, then low
            next_r.step = r.step + 2'h1;
            if (r.step == 2'h0) begin
                next_r.sp = r.sp + 16'h0001;
                next_r.mem_addr = r.sp + 16'h0001;
            end else if (r.step == 2'h1) begin
                next_r.pc[15:8] = I_MEM_RDATA;
            end else begin
                next_r.pc[7:0] = I_MEM_RDATA;
                next_r.st = cpuc_pkg::CPUC_ST_RUN;
                if (r.return_from_irq_op) begin
                    next_r.flags[`CPUC_FLG_I] = 1'b1;
                end
            end
        end else if (found && r.flags[`CPUC_FLG_I]) begin
            // Flags left untouched apart from enable
            next_r.flags[`CPUC_FLG_I] = 1'b0;
            next_r.ret_pc = r.pc;
            next_r.dest = 16'({pick, 1'b0}) + `CPUC_VEC_STEP;
            next_r.st = cpuc_pkg::CPUC_ST_PUSH;
            next_r.step = 2'h0;
            next_r.ack = 1'b1;
            next_r.irq_num = pick;
        end else if (I_INSTR_VALID) begin
            next_r.pc = r.pc + (I_TWO_WORD ? 16'h0002 : 16'h0001);
            if (I_TWO_WORD) begin
                next_r.ir2 = I_FETCH_WORD;
            end
            case (I_OP)
                cpuc_pkg::CPUC_OP_ALU: begin
                    if (wr_res) begin
                        next_r.rf[I_RD] = res;
                        next_r.flags[`CPUC_FLG_H] = h;
                        next_r.flags[`CPUC_FLG_V] = v;
                        next_r.flags[`CPUC_FLG_N] = res[7];
                        next_r.flags[`CPUC_FLG_S] = res[7] ^ v;
                        next_r.flags[`CPUC_FLG_Z] = (res == 8'h00);
                        next_r.flags[`CPUC_FLG_C] = c;
                    end
                end
                cpuc_pkg::CPUC_OP_BST: next_r.flags[`CPUC_FLG_T] = a[I_BIT];
                cpuc_pkg::CPUC_OP_BLD: next_r.rf[I_RD][I_BIT] = r.flags[`CPUC_FLG_T];
                cpuc_pkg::CPUC_OP_SEI: next_r.flags[`CPUC_FLG_I] = 1'b1;
                cpuc_pkg::CPUC_OP_CLI: next_r.flags[`CPUC_FLG_I] = 1'b0;
                cpuc_pkg::CPUC_OP_CALL: begin
                    next_r.ret_pc = r.pc + (I_TWO_WORD ? 16'h0002 : 16'h0001);
                    next_r.dest = I_TARGET;
                    next_r.st = cpuc_pkg::CPUC_ST_PUSH;
                    next_r.step = 2'h0;
                end
                cpuc_pkg::CPUC_OP_RET, cpuc_pkg::CPUC_OP_RETURN_FROM_IRQ_OP: begin
                    next_r.return_from_irq_op = (I_OP == cpuc_pkg::CPUC_OP_RETURN_FROM_IRQ_OP);
                    next_r.sp = r.sp + 16'h0001;
                    next_r.mem_addr = r.sp + 16'h0001;
                    next_r.st = cpuc_pkg::CPUC_ST_POP;
                    next_r.step = 2'h0;
                end
                cpuc_pkg::CPUC_OP_SPM: begin
                    // App-section writes need boot-resident code
                    if (zptr < `CPUC_BOOT_START && r.pc < `CPUC_BOOT_START) begin
                        next_r.spm_ref = 1'b1;
                    end else begin
                        next_r.fl_addr = zptr;
                        next_r.fl_we = 1'b1;
                    end
                end
                cpuc_pkg::CPUC_OP_LDP: next_r.fl_addr = zptr;
                default: ;
            endcase
        end
        // Register port: data 0x20..0x5F mirrors I/O 0x00..0x3F
        if (I_WR) begin
            if (I_ADDR < 8'h20) begin
                next_r.rf[I_ADDR[4:0]] = I_WDATA;
            end else if (I_ADDR == `CPUC_ADR_FLAGS + 8'h20) begin
                next_r.flags = I_WDATA;
            end else if (I_ADDR == `CPUC_ADR_SP_LO + 8'h20) begin
                next_r.sp[7:0] = I_WDATA;
            end else if (I_ADDR == `CPUC_ADR_SP_HI + 8'h20) begin
                next_r.sp[15:8] = I_WDATA;
            end
        end
        next_r.rdata = 8'h00;
        if (I_RD_STB) begin
            if (I_ADDR < 8'h20) begin
                next_r.rdata = r.rf[I_ADDR[4:0]];
            end else if (I_ADDR == `CPUC_ADR_FLAGS + 8'h20) begin
                next_r.rdata = r.flags;
            end else if (I_ADDR == `CPUC_ADR_SP_LO + 8'h20) begin
                next_r.rdata = r.sp[7:0];
            end else if (I_ADDR == `CPUC_ADR_SP_HI + 8'h20) begin
                next_r.rdata = r.sp[15:8];
            end
        end
    end

    always_ff @(posedge I_REF_CLK) begin
        if (I_RST) begin
            r <= '0;
            r.flags <= `CPUC_FLAGS_RST;
            r.sp <= `CPUC_SP_RST;
            r.st <= cpuc_pkg::CPUC_ST_RUN;
        end else begin
            r <= next_r;
        end
    end

    assign O_RDATA = r.rdata;
    assign O_PC = r.pc;
    assign O_FLAGS = r.flags;
    assign O_MEM_ADDR = r.mem_addr;
    assign O_MEM_WDATA = r.mem_wdata;
    assign O_MEM_WE = r.mem_we;
    assign O_FLASH_ADDR = r.fl_addr;
    assign O_FLASH_WE = r.fl_we;
    assign O_IRQ_ACK = r.ack;
    assign O_IRQ_NUM = r.irq_num;
    assign O_SPM_REFUSED = r.spm_ref;

    sequence s_push_two;
        O_MEM_WE ##1 O_MEM_WE;
    endsequence

    AST_SIGN: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
        O_FLAGS[`CPUC_FLG_S] == (O_FLAGS[`CPUC_FLG_N] ^ O_FLAGS[`CPUC_FLG_V])
        || $past(I_WR)) else $error("sign bit mismatch");
    AST_ACK_CLR_I: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
        O_IRQ_ACK |-> !O_FLAGS[`CPUC_FLG_I]) else $error("enable kept on entry");
    AST_ACK_NEEDS_I: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
        $rose(O_IRQ_ACK) |-> $past(O_FLAGS[`CPUC_FLG_I])) else $error("irq while off");
    AST_PUSH: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
        O_IRQ_ACK |=> s_push_two) else $error("return not pushed");
    AST_SP_DEC: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
        O_IRQ_ACK |-> ##2 (r.sp == $past(r.sp, 2) - 16'h0002)) else $error("sp not -2");
    AST_ZERO: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
        (I_INSTR_VALID && I_OP == cpuc_pkg::CPUC_OP_ALU && wr_res && !I_WR
        && r.st == cpuc_pkg::CPUC_ST_RUN && !(found && r.flags[`CPUC_FLG_I]))
        |=> O_FLAGS[`CPUC_FLG_Z] == ($past(res) == 8'h00)) else $error("zero flag");
    AST_SPM: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
        O_FLASH_WE |-> !(O_FLASH_ADDR < `CPUC_BOOT_START && $past(r.pc) < `CPUC_BOOT_START))
        else $error("app write from app code");
    AST_RESET: assert property (@(posedge I_REF_CLK)
        $past(I_RST) |-> O_FLAGS == `CPUC_FLAGS_RST) else $error("flags not clear");
endmodule : cpuc_core

// >>> dv/cpuc_dmem_model.sv
`timescale 1ns/1ps
module cpuc_dmem_model (
    input  wire logic        i_clk,
    input  wire logic [15:0] i_addr,
    input  wire logic [7:0]  i_wdata,
    input  wire logic        i_we,
    output logic      [7:0]  o_rdata
);
    logic [7:0] mem [256];

    initial begin
        foreach (mem[i]) begin
            mem[i] = 8'h00;
        end
    end

    // Data SRAM behind the stack: read data one cycle after the address
    always @(posedge i_clk) begin
        if (i_we) begin
            mem[i_addr[7:0]] <= i_wdata;
        end
        o_rdata <= mem[i_addr[7:0]];
    end
endmodule : cpuc_dmem_model

// >>> dv/cpu_core_alu_status_flags_test.sv
`timescale 1ns/1ps
module cpu_core_alu_status_flags_test;
    typedef struct {
        cpuc_pkg::cpuc_alu_t fn;
        logic [7:0]          a;
        logic [7:0]          b;
        logic [7:0]          r;
        logic [7:0]          f;
        logic [7:0]          m;
    } cpuc_row_t;

    // Operands, result, flags and the mask of flags the operation defines
    cpuc_row_t rows [8] = '{
        '{cpuc_pkg::CPUC_ADD, 8'h0F, 8'h01, 8'h10, 8'h20, 8'h3F},
        '{cpuc_pkg::CPUC_ADD, 8'h7F, 8'h01, 8'h80, 8'h2C, 8'h3F},
        '{cpuc_pkg::CPUC_ADD, 8'hFF, 8'h01, 8'h00, 8'h23, 8'h3F},
        '{cpuc_pkg::CPUC_SUB, 8'h00, 8'h01, 8'hFF, 8'h35, 8'h3F},
        '{cpuc_pkg::CPUC_SUB, 8'h80, 8'h01, 8'h7F, 8'h38, 8'h3F},
        '{cpuc_pkg::CPUC_AND, 8'hF0, 8'h0F, 8'h00, 8'h02, 8'h1E},
        '{cpuc_pkg::CPUC_EOR, 8'h80, 8'h00, 8'h80, 8'h14, 8'h1E},
        '{cpuc_pkg::CPUC_INC, 8'h7F, 8'h00, 8'h80, 8'h0C, 8'h1E}
    };

    logic                clk    = 1'b0;
    logic                rst    = 1'b1;
    logic                vld    = 1'b0;
    logic                imm_en = 1'b0;
    logic                wr     = 1'b0;
    logic                rds    = 1'b0;
    cpuc_pkg::cpuc_op_t  op     = cpuc_pkg::CPUC_OP_NONE;
    cpuc_pkg::cpuc_alu_t fn     = cpuc_pkg::CPUC_NOP;
    logic [4:0]          rd     = 5'h00;
    logic [4:0]          rr     = 5'h00;
    logic [7:0]          imm    = 8'h00;
    logic [2:0]          bsel   = 3'h0;
    logic [7:0]          irq    = 8'h00;
    logic [7:0]          adr    = 8'h00;
    logic [7:0]          wd     = 8'h00;
    logic [7:0]          rdata;
    logic [7:0]          flags;
    logic [7:0]          mwd;
    logic [7:0]          mrd;
    logic [15:0]         pc;
    logic [15:0]         maddr;
    logic [15:0]         faddr;
    logic                mwe;
    logic                fwe;
    logic                ack;
    logic                refused;
    logic [2:0]          inum;
    logic [7:0]          v;
    logic [15:0]         pc0;
    int                  bad_count   = 0;
    int                  checks_done = 0;
    int                  cyc         = 0;
    int                  n;

    always #2.5 clk = ~clk;

    cpuc_core u_cpuc_core (
        .I_REF_CLK(clk), .I_RST(rst), .I_INSTR_VALID(vld), .I_OP(op), .I_ALU_FN(fn),
        .I_USE_IMM(imm_en), .I_TWO_WORD(1'b0), .I_RD(rd), .I_RR(rr), .I_IMM(imm),
        .I_BIT(bsel), .I_TARGET(16'h0000), .I_FETCH_WORD(16'h0000), .I_IRQ(irq),
        .I_MEM_RDATA(mrd), .I_ADDR(adr), .I_WDATA(wd), .I_WR(wr), .I_RD_STB(rds),
        .O_RDATA(rdata), .O_PC(pc), .O_FLAGS(flags), .O_MEM_ADDR(maddr),
        .O_MEM_WDATA(mwd), .O_MEM_WE(mwe), .O_FLASH_ADDR(faddr), .O_FLASH_WE(fwe),
        .O_IRQ_ACK(ack), .O_IRQ_NUM(inum), .O_SPM_REFUSED(refused)
    );

    cpuc_dmem_model u_cpuc_dmem_model (
        .i_clk(clk), .i_addr(maddr), .i_wdata(mwd), .i_we(mwe), .o_rdata(mrd)
    );

    task results;
        $display("checks %0d errors %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : results

    task chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask : chk

    // Bit index rides on the low bits of k
    task exec(input cpuc_pkg::cpuc_op_t o, input cpuc_pkg::cpuc_alu_t f, input logic ui,
              input logic [4:0] d, input logic [4:0] s, input logic [7:0] k);
        @(posedge clk);
        vld <= 1'b1;
        op <= o;
        fn <= f;
        imm_en <= ui;
        rd <= d;
        rr <= s;
        imm <= k;
        bsel <= k[2:0];
        @(posedge clk);
        vld <= 1'b0;
        #1;
    endtask : exec

    task ldi(input logic [4:0] d, input logic [7:0] k);
        exec(cpuc_pkg::CPUC_OP_ALU, cpuc_pkg::CPUC_MOV, 1'b1, d, 5'h00, k);
    endtask : ldi

    task rreg(input logic [7:0] a, output logic [7:0] q);
        @(posedge clk);
        rds <= 1'b1;
        adr <= a;
        @(posedge clk);
        rds <= 1'b0;
        #1;
        q = rdata;
    endtask : rreg

    task wreg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        wr <= 1'b1;
        adr <= a;
        wd <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wreg

    task wait_cyc(input int c);
        repeat (c) @(posedge clk);
        #1;
    endtask : wait_cyc

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            bad_count++;
            results();
        end
    end

    initial begin
        wait_cyc(10);
        chk(flags, 8'h00);
        @(posedge clk);
        rst <= 1'b0;
        foreach (rows[i]) begin
            ldi(5'd16, rows[i].a);
            ldi(5'd17, rows[i].b);
            exec(cpuc_pkg::CPUC_OP_ALU, rows[i].fn, 1'b0, 5'd16, 5'd17, 8'h00);
            chk(flags & rows[i].m, rows[i].f);
            rreg(8'h10, v);
            chk(v, rows[i].r);
        end
        exec(cpuc_pkg::CPUC_OP_SEI, cpuc_pkg::CPUC_NOP, 1'b0, 5'd0, 5'd0, 8'h00);
        chk(flags[7], 1'b1);
        exec(cpuc_pkg::CPUC_OP_CLI, cpuc_pkg::CPUC_NOP, 1'b0, 5'd0, 5'd0, 8'h00);
        chk(flags[7], 1'b0);
        ldi(5'd16, 8'h08);
        exec(cpuc_pkg::CPUC_OP_BST, cpuc_pkg::CPUC_NOP, 1'b0, 5'd16, 5'd0, 8'h03);
        chk(flags[6], 1'b1);
        ldi(5'd17, 8'h00);
        exec(cpuc_pkg::CPUC_OP_BLD, cpuc_pkg::CPUC_NOP, 1'b0, 5'd17, 5'd0, 8'h05);
        rreg(8'h11, v);
        chk(v, 8'h20);
        wreg(8'h5F, 8'h03);
        rreg(8'h5F, v);
        chk(v, 8'h03);
        rreg(8'hF0, v);
        chk(v, 8'h00);
        wreg(8'h5D, 8'h10);
        wreg(8'h5E, 8'h01);
        rreg(8'h5E, v);
        chk(v, 8'h01);
        @(posedge clk);
        irq <= 8'h24;
        n = 0;
        repeat (12) begin
            wait_cyc(1);
            n += int'(ack === 1'b1);
        end
        chk(n[15:0], 16'h0000);
        exec(cpuc_pkg::CPUC_OP_SEI, cpuc_pkg::CPUC_NOP, 1'b0, 5'd0, 5'd0, 8'h00);
        n = 0;
        while (ack !== 1'b1 && n < 20) begin
            wait_cyc(1);
            n++;
        end
        pc0 = pc;
        chk(ack, 1'b1);
        chk(inum, 3'h2);
        chk(flags, 8'h03);
        @(posedge clk);
        irq <= 8'h00;
        wait_cyc(3);
        chk(pc, 16'h0006);
        chk({u_cpuc_dmem_model.mem[8'h0F], u_cpuc_dmem_model.mem[8'h10]}, pc0);
        rreg(8'h5D, v);
        chk(v, 8'h0E);
        exec(cpuc_pkg::CPUC_OP_RETURN_FROM_IRQ_OP, cpuc_pkg::CPUC_NOP, 1'b0, 5'd0, 5'd0, 8'h00);
        wait_cyc(3);
        chk(pc, pc0);
        chk(flags, 8'h83);
        rreg(8'h5D, v);
        chk(v, 8'h10);
        ldi(5'd30, 8'h00);
        ldi(5'd31, 8'h01);
        exec(cpuc_pkg::CPUC_OP_SPM, cpuc_pkg::CPUC_NOP, 1'b0, 5'd0, 5'd0, 8'h00);
        chk(refused, 1'b1);
        chk(fwe, 1'b0);
        exec(cpuc_pkg::CPUC_OP_LDP, cpuc_pkg::CPUC_NOP, 1'b0, 5'd0, 5'd0, 8'h00);
        chk(faddr, 16'h0100);
        ldi(5'd31, 8'h70);
        exec(cpuc_pkg::CPUC_OP_SPM, cpuc_pkg::CPUC_NOP, 1'b0, 5'd0, 5'd0, 8'h00);
        chk(fwe, 1'b1);
        chk(faddr, 16'h7000);
        @(posedge clk);
        rst <= 1'b1;
        wait_cyc(2);
        chk(flags, 8'h00);
        @(posedge clk);
        rst <= 1'b0;
        wait_cyc(2);
        chk(flags, 8'h00);
        results();
    end
endmodule : cpu_core_alu_status_flags_test
